// >>> controller_fault_status_reg.sv
/*
 * controller fault status register with its apb slave, a control word,
 * a clear word, a raw source view and a fault episode counter.
 * assumes fault sources are driven by detection logic on i_mclk.
 */
// The implementer's own choice: the APB slave port.
module controller_fault_status_reg (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [fault_status_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [fault_status_pkg::DATA_W-1:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [fault_status_pkg::DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_posdetect_freq_err,
    input wire logic i_posdetect_timing1_err,
    input wire logic i_posdetect_timing2_err,
    input wire logic i_bus_current_limit_flag,
    input wire logic i_param_meas_rl_err,
    input wire logic i_param_meas_backemf_err,
    input wire logic i_abnormal_speed_lock,
    input wire logic i_abnormal_backemf_lock,
    input wire logic i_motor_absent_flag,
    input wire logic i_lock_current_limit_flag,
    input wire logic i_hw_lock_current_limit_flag,
    input wire logic i_motor_supply_low_flag,
    input wire logic i_motor_supply_high_flag,
    input wire logic i_speed_loop_sat_flag,
    input wire logic i_current_loop_sat_flag,
    output logic o_controller_fault
);

    fault_status_pkg::bus_state_t state;
    fault_status_pkg::bus_state_t next_state;

    logic [fault_status_pkg::NFLAG-1:0] src;
    logic [fault_status_pkg::NFLAG-1:0] flag;
    logic [fault_status_pkg::NFLAG-1:0] clear_vec;
    logic [31:0] fault_word;
    logic [31:0] raw_word;
    logic [31:0] ctrl;
    logic [31:0] wmask;
    logic [31:0] clear_bits;
    logic [31:0] read_word;
    logic [fault_status_pkg::COUNT_W-1:0] episode_count;
    logic summary;
    logic summary_q;
    logic any_lock;
    logic sel_fault;
    logic sel_ctrl;
    logic sel_clear;
    logic sel_raw;
    logic sel_count;
    logic mapped;
    logic read_only;
    logic bad_access;
    logic wr_en;

    // source order inside the flag bank, highest bit first
    assign src = {
        i_posdetect_freq_err,
        i_posdetect_timing1_err,
        i_posdetect_timing2_err,
        i_bus_current_limit_flag,
        i_param_meas_rl_err,
        i_param_meas_backemf_err,
        i_abnormal_speed_lock,
        i_abnormal_backemf_lock,
        i_motor_absent_flag,
        i_lock_current_limit_flag,
        i_hw_lock_current_limit_flag,
        i_motor_supply_low_flag,
        i_motor_supply_high_flag,
        i_speed_loop_sat_flag,
        i_current_loop_sat_flag
    };

    // address decode on word index; the low two address bits are ignored
    assign sel_fault = (i_paddr[11:2] == fault_status_pkg::FAULT_IDX);
    assign sel_ctrl = (i_paddr[11:2] == fault_status_pkg::CTRL_IDX);
    assign sel_clear = (i_paddr[11:2] == fault_status_pkg::CLEAR_IDX);
    assign sel_raw = (i_paddr[11:2] == fault_status_pkg::RAW_IDX);
    assign sel_count = (i_paddr[11:2] == fault_status_pkg::COUNT_IDX);
    assign mapped = sel_fault | sel_ctrl | sel_clear | sel_raw | sel_count;
    assign read_only = sel_fault | sel_raw;
    assign bad_access = !mapped || (i_pwrite && read_only);

    // writes land only on the edge that completes the access
    assign wr_en = (state == fault_status_pkg::ST_ACK) && i_psel && i_penable
        && i_pwrite && !bad_access;

    assign wmask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

    // bus state machine: one wait state so read data comes from a flop
    always_comb begin
        next_state = state;
        case (state)
            fault_status_pkg::ST_IDLE: begin
                if (i_psel) begin
                    next_state = fault_status_pkg::ST_FETCH;
                end
            end
            fault_status_pkg::ST_FETCH: begin
                if (i_psel && i_penable) begin
                    next_state = fault_status_pkg::ST_ACK;
                end
            end
            fault_status_pkg::ST_ACK: begin
                next_state = fault_status_pkg::ST_IDLE;
            end
            default: begin
                next_state = fault_status_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= fault_status_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign o_pready = (state == fault_status_pkg::ST_ACK);

    // control word: only the live-mode bit is kept, the rest reads zero
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl <= fault_status_pkg::CTRL_RESET;
        end else if (wr_en && sel_ctrl && i_pstrb[0]) begin
            ctrl[fault_status_pkg::BIT_LIVE] <= i_pwdata[fault_status_pkg::BIT_LIVE];
        end
    end

    // clear word is write-one-to-clear and acts for one cycle only;
    // writing the summary bit clears every flag at once
    always_comb begin
        clear_bits = 32'h0000_0000;
        if (wr_en && sel_clear) begin
            clear_bits = i_pwdata & wmask;
            if (clear_bits[fault_status_pkg::BIT_SUMMARY]) begin
                clear_bits = 32'hFFFF_FFFF;
            end
        end
    end

    assign clear_vec = {
        clear_bits[fault_status_pkg::BIT_POS_FREQ],
        clear_bits[fault_status_pkg::BIT_POS_T1],
        clear_bits[fault_status_pkg::BIT_POS_T2],
        clear_bits[fault_status_pkg::BIT_BUS_ILIM],
        clear_bits[fault_status_pkg::BIT_MEAS_RL],
        clear_bits[fault_status_pkg::BIT_MEAS_BACK_EMF],
        clear_bits[fault_status_pkg::BIT_ABNORMAL_SPEED_LOCK],
        clear_bits[fault_status_pkg::BIT_ABNORMAL_BACKEMF_LOCK],
        clear_bits[fault_status_pkg::BIT_NO_MOTOR],
        clear_bits[fault_status_pkg::BIT_LOCK_ILIM],
        clear_bits[fault_status_pkg::BIT_HW_LOCK_ILIM],
        clear_bits[fault_status_pkg::BIT_SUPPLY_LOW],
        clear_bits[fault_status_pkg::BIT_SUPPLY_HIGH],
        clear_bits[fault_status_pkg::BIT_SPEED_SAT],
        clear_bits[fault_status_pkg::BIT_CURRENT_SAT]
    };

    fault_flag_bank #(
        .WIDTH(fault_status_pkg::NFLAG)
    ) u_flags (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_live(ctrl[fault_status_pkg::BIT_LIVE]),
        .i_event(src),
        .i_clear(clear_vec),
        .o_flag(flag)
    );

    // lock summary covers the five lock detections
    assign any_lock = flag[8] | flag[7] | flag[6] | flag[5] | flag[4];

    // map flags onto the fault word; unlisted bits stay zero
    always_comb begin
        fault_word = fault_status_pkg::FAULT_RESET;
        fault_word[fault_status_pkg::BIT_POS_FREQ] = flag[14];
        fault_word[fault_status_pkg::BIT_POS_T1] = flag[13];
        fault_word[fault_status_pkg::BIT_POS_T2] = flag[12];
        fault_word[fault_status_pkg::BIT_BUS_ILIM] = flag[11];
        fault_word[fault_status_pkg::BIT_MEAS_RL] = flag[10];
        fault_word[fault_status_pkg::BIT_MEAS_BACK_EMF] = flag[9];
        fault_word[fault_status_pkg::BIT_ABNORMAL_SPEED_LOCK] = flag[8];
        fault_word[fault_status_pkg::BIT_ABNORMAL_BACKEMF_LOCK] = flag[7];
        fault_word[fault_status_pkg::BIT_NO_MOTOR] = flag[6];
        fault_word[fault_status_pkg::BIT_ANY_LOCK] = any_lock;
        fault_word[fault_status_pkg::BIT_LOCK_ILIM] = flag[5];
        fault_word[fault_status_pkg::BIT_HW_LOCK_ILIM] = flag[4];
        fault_word[fault_status_pkg::BIT_SUPPLY_LOW] = flag[3];
        fault_word[fault_status_pkg::BIT_SUPPLY_HIGH] = flag[2];
        fault_word[fault_status_pkg::BIT_SPEED_SAT] = flag[1];
        fault_word[fault_status_pkg::BIT_CURRENT_SAT] = flag[0];
        // summary built from this very word, so one read is self-consistent
        fault_word[fault_status_pkg::BIT_SUMMARY] = |fault_word[29:14];
    end

    assign summary = fault_word[fault_status_pkg::BIT_SUMMARY];

    // raw view shows the sources at the same positions, without latching
    always_comb begin
        raw_word = 32'h0000_0000;
        raw_word[fault_status_pkg::BIT_POS_FREQ] = src[14];
        raw_word[fault_status_pkg::BIT_POS_T1] = src[13];
        raw_word[fault_status_pkg::BIT_POS_T2] = src[12];
        raw_word[fault_status_pkg::BIT_BUS_ILIM] = src[11];
        raw_word[fault_status_pkg::BIT_MEAS_RL] = src[10];
        raw_word[fault_status_pkg::BIT_MEAS_BACK_EMF] = src[9];
        raw_word[fault_status_pkg::BIT_ABNORMAL_SPEED_LOCK] = src[8];
        raw_word[fault_status_pkg::BIT_ABNORMAL_BACKEMF_LOCK] = src[7];
        raw_word[fault_status_pkg::BIT_NO_MOTOR] = src[6];
        raw_word[fault_status_pkg::BIT_ANY_LOCK] = |src[8:4];
        raw_word[fault_status_pkg::BIT_LOCK_ILIM] = src[5];
        raw_word[fault_status_pkg::BIT_HW_LOCK_ILIM] = src[4];
        raw_word[fault_status_pkg::BIT_SUPPLY_LOW] = src[3];
        raw_word[fault_status_pkg::BIT_SUPPLY_HIGH] = src[2];
        raw_word[fault_status_pkg::BIT_SPEED_SAT] = src[1];
        raw_word[fault_status_pkg::BIT_CURRENT_SAT] = src[0];
        raw_word[fault_status_pkg::BIT_SUMMARY] = |src;
    end

    // episode counter: counts rising edges of the summary, saturating;
    // a write clears it, but an edge in that same cycle still counts
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            summary_q <= 1'b0;
        end else begin
            summary_q <= summary;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            episode_count <= fault_status_pkg::COUNT_RESET;
        end else if (wr_en && sel_count) begin
            episode_count <= {{(fault_status_pkg::COUNT_W-1){1'b0}}, summary && !summary_q};
        end else if (summary && !summary_q && episode_count != fault_status_pkg::COUNT_MAX) begin
            episode_count <= episode_count + 1'b1;
        end
    end

    // read mux; the clear word always reads zero
    always_comb begin
        read_word = 32'h0000_0000;
        if (sel_fault) begin
            read_word = fault_word;
        end else if (sel_ctrl) begin
            read_word = ctrl;
        end else if (sel_raw) begin
            read_word = raw_word;
        end else if (sel_count) begin
            read_word = {16'h0000, episode_count};
        end
    end

    // read data and error are captured in the first access cycle
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (state == fault_status_pkg::ST_FETCH && i_psel && i_penable) begin
            o_prdata <= (i_pwrite || bad_access) ? 32'h0000_0000 : read_word;
            o_pslverr <= bad_access;
        end
    end

    // summary also leaves the block as a level for the fault pin logic
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_controller_fault <= 1'b0;
        end else begin
            o_controller_fault <= summary;
        end
    end

endmodule : controller_fault_status_reg

// >>> fault_status_pkg.sv
/*
 * constants for the controller fault status block: register indices, bit
 * positions, reset values and the bus state encoding.
 * assumes an apb master with 32-bit data; every register takes one aligned
 * word and its byte address is four times its index.
 */
// How it works
// - fault word at index E2h, read-only, 32 bits, zero after reset
// - bit 31 is the OR of every controller fault flag
// - bit 29 reports a position-detection frequency fault
// - bit 28 reports the first position-detection timing fault
// - bit 27 reports the second position-detection timing fault
// - bit 26 reports a bus current limit fault
// - bit 25 reports a resistance and inductance measurement error
// - bit 24 reports a back-emf constant measurement error
// - bit 23 reports an abnormal-speed motor lock
// - bit 22 reports an abnormal back-emf motor lock
// - bit 21 reports that no motor is connected
// - bit 20 is set when any motor lock detection has triggered
// - bit 19 lock current limit, bit 18 hardware lock current limit
// - bit 17 motor supply undervoltage, bit 16 motor supply overvoltage
// - bit 15 speed loop, bit 14 current loop saturation; 13..0 read zero
package fault_status_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register indices; byte address is index times four
    localparam logic [9:0] FAULT_IDX = 10'h0E2;
    localparam logic [9:0] CTRL_IDX = 10'h0F0;
    localparam logic [9:0] CLEAR_IDX = 10'h0F1;
    localparam logic [9:0] RAW_IDX = 10'h0F2;
    localparam logic [9:0] COUNT_IDX = 10'h0F3;

    localparam logic [31:0] FAULT_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam int COUNT_W = 16;

    // number of flags held by the flag bank
    localparam int NFLAG = 15;

    // bit positions in the fault word
    localparam int BIT_SUMMARY = 31;
    localparam int BIT_POS_FREQ = 29;
    localparam int BIT_POS_T1 = 28;
    localparam int BIT_POS_T2 = 27;
    localparam int BIT_BUS_ILIM = 26;
    localparam int BIT_MEAS_RL = 25;
    localparam int BIT_MEAS_BACK_EMF = 24;
    localparam int BIT_ABNORMAL_SPEED_LOCK = 23;
    localparam int BIT_ABNORMAL_BACKEMF_LOCK = 22;
    localparam int BIT_NO_MOTOR = 21;
    localparam int BIT_ANY_LOCK = 20;
    localparam int BIT_LOCK_ILIM = 19;
    localparam int BIT_HW_LOCK_ILIM = 18;
    localparam int BIT_SUPPLY_LOW = 17;
    localparam int BIT_SUPPLY_HIGH = 16;
    localparam int BIT_SPEED_SAT = 15;
    localparam int BIT_CURRENT_SAT = 14;

    // control word: bit 0 selects live mode (flags follow their sources)
    localparam int BIT_LIVE = 0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FETCH = 3'b010,
        ST_ACK = 3'b100
    } bus_state_t;

endpackage : fault_status_pkg

// >>> fault_flag_bank.sv
/*
 * bank of fault flags: each flag is sticky or follows its source live.
 * assumes event inputs come from logic on the same clock.
 */
module fault_flag_bank #(
    parameter int WIDTH = 15
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_live,
    input wire logic [WIDTH-1:0] i_event,
    input wire logic [WIDTH-1:0] i_clear,
    output logic [WIDTH-1:0] o_flag
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_flag
            // a new event in the clearing cycle wins so no fault is lost
            always_ff @(posedge i_mclk or negedge i_resetn) begin
                if (!i_resetn) begin
                    o_flag[g] <= 1'b0;
                end else if (i_live) begin
                    o_flag[g] <= i_event[g];
                end else begin
                    o_flag[g] <= i_event[g] | (o_flag[g] & ~i_clear[g]);
                end
            end
        end
    endgenerate

endmodule : fault_flag_bank

// >>> controller_fault_status_properties.sv
/*
 * checker for the controller fault status register: bus timing and the fault word.
 * assumes a master that holds each request until pready, as the bus asks.
 */
module controller_fault_status_properties (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [fault_status_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [fault_status_pkg::DATA_W-1:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_posdetect_freq_err,
    input wire logic i_motor_absent_flag,
    input wire logic o_controller_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    logic on_fault;
    logic fault_rd;
    assign on_fault = (i_paddr[11:2] == fault_status_pkg::FAULT_IDX);
    assign fault_rd = o_pready && !i_pwrite && on_fault;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    a_one_wait_state: assert property (
        (i_psel && !i_penable) |=> !o_pready ##1 o_pready)
        else $error("pready not in the third cycle of a transfer");
    a_ready_single_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready held longer than one cycle");
    a_ready_in_access: assert property (o_pready |-> (i_psel && i_penable))
        else $error("pready outside an access phase");
    a_fault_write_refused: assert property (
        (o_pready && i_pwrite && on_fault) |-> o_pslverr)
        else $error("write to the fault word not refused");
    a_fault_read_clean: assert property (fault_rd |-> !o_pslverr)
        else $error("read of the fault word refused");
    a_reserved_bits_zero: assert property (
        fault_rd |-> (o_prdata[30] == 1'b0 && o_prdata[13:0] == 14'h0000))
        else $error("reserved bits of the fault word not zero");
    a_summary_or_flags: assert property (
        fault_rd |-> (o_prdata[31] == (|o_prdata[29:14])))
        else $error("summary bit disagrees with the flags");
    a_lock_summary: assert property (fault_rd |-> (o_prdata[20] ==
        (o_prdata[23] | o_prdata[22] | o_prdata[21] | o_prdata[19] | o_prdata[18])))
        else $error("any-lock bit disagrees with the lock flags");
    a_source_to_summary: assert property (
        (i_posdetect_freq_err || i_motor_absent_flag) |-> ##2 o_controller_fault)
        else $error("fault source did not reach the summary output");

    cover property (fault_rd && o_prdata[31]);
    cover property (o_pready && o_pslverr);
    cover property ($rose(o_controller_fault));
endmodule : controller_fault_status_properties

bind controller_fault_status_reg controller_fault_status_properties u_props (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_posdetect_freq_err(i_posdetect_freq_err),
    .i_motor_absent_flag(i_motor_absent_flag), .o_controller_fault(o_controller_fault));

// >>> test_controller_fault_status_reg.sv
/*
 * self-checking bench for the controller fault status register.
 * assumes sticky flags after reset, the clear word at 0x3C4 and live mode in the control word.
 */
module test_controller_fault_status_reg;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk;
    logic resetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [3:0] strb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ctrl_fault;
    logic [31:0] src;
    logic [31:0] rd;
    logic err;
    logic [31:0] exp;
    int errors;
    int n_compared;

    controller_fault_status_reg u_dut (
        .i_mclk(mclk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_posdetect_freq_err(src[29]), .i_posdetect_timing1_err(src[28]),
        .i_posdetect_timing2_err(src[27]), .i_bus_current_limit_flag(src[26]),
        .i_param_meas_rl_err(src[25]), .i_param_meas_backemf_err(src[24]),
        .i_abnormal_speed_lock(src[23]), .i_abnormal_backemf_lock(src[22]),
        .i_motor_absent_flag(src[21]), .i_lock_current_limit_flag(src[19]),
        .i_hw_lock_current_limit_flag(src[18]), .i_motor_supply_low_flag(src[17]),
        .i_motor_supply_high_flag(src[16]), .i_speed_loop_sat_flag(src[15]),
        .i_current_loop_sat_flag(src[14]), .o_controller_fault(ctrl_fault));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic report_and_stop;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, want);
        end
    endtask : check

    // one transfer; the idle edge first keeps psel from being driven twice in a step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= strb;
        @(posedge mclk);
        penable <= 1'b1;
        // request stands until an edge samples pready high; only the watchdog ends a hang
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pulse(input logic [31:0] m);
        @(posedge mclk);
        src <= m;
        @(posedge mclk);
        src <= 32'h0000_0000;
        repeat (2) @(posedge mclk);
    endtask : pulse

    initial begin
        #2000000;
        errors++;
        report_and_stop();
    end

    initial begin
        errors = 0;
        n_compared = 0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        strb = 4'hF;
        src = 32'h0000_0000;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        apb(1'b0, 12'h388, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0000);
        apb(1'b1, 12'h388, 32'hFFFF_FFFF);
        check({31'h0, err}, 32'h0000_0001);
        apb(1'b0, 12'h388, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b0, 12'h3FC, 32'h0000_0000);
        check({rd[30:0], err}, 32'h0000_0001);
        // each source alone, then the clear-all word; bit 20 is derived, not a source
        for (int p = 14; p < 30; p++) begin
            if (p != 20) begin
                exp = (32'h1 << p) | 32'h8000_0000;
                if (p == 23 || p == 22 || p == 21 || p == 19 || p == 18) begin
                    exp = exp | 32'h0010_0000;
                end
                pulse(32'h1 << p);
                apb(1'b0, 12'h388, 32'h0000_0000);
                check(rd, exp);
                check(rd, exp);
                check({31'h0, ctrl_fault}, 32'h0000_0001);
                apb(1'b1, 12'h3C4, 32'h8000_0000);
                apb(1'b0, 12'h388, 32'h0000_0000);
                check(rd, 32'h0000_0000);
                check({31'h0, ctrl_fault}, 32'h0000_0000);
            end
        end
        // live mode: flags follow a held source and drop with it, no clear needed
        apb(1'b1, 12'h3C0, 32'h0000_0001);
        apb(1'b0, 12'h3C0, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        src <= 32'h0400_0000;
        apb(1'b0, 12'h388, 32'h0000_0000);
        check(rd, 32'h8400_0000);
        apb(1'b0, 12'h3C8, 32'h0000_0000);
        check(rd, 32'h8400_0000);
        apb(1'b1, 12'h3C8, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        src <= 32'h0000_0000;
        apb(1'b0, 12'h388, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        // a write with lane 0 off leaves the live bit alone
        strb = 4'hE;
        apb(1'b1, 12'h3C0, 32'h0000_0000);
        strb = 4'hF;
        apb(1'b0, 12'h3C0, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        apb(1'b1, 12'h3C0, 32'h0000_0000);
        apb(1'b0, 12'h3C0, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        // episode counter: cleared by a write, one rising summary counts once
        apb(1'b1, 12'h3CC, 32'h0000_0000);
        pulse(32'h0000_4000);
        apb(1'b0, 12'h3CC, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        apb(1'b1, 12'h3C4, 32'h8000_0000);
        // two flags at once, one clear lifts only its own flag
        pulse(32'h2008_0000);
        apb(1'b1, 12'h3C4, 32'h2000_0000);
        apb(1'b0, 12'h388, 32'h0000_0000);
        check(rd, 32'h8018_0000);
        // reset in mid-run drops every sticky flag and the summary output
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        check({31'h0, ctrl_fault}, 32'h0000_0000);
        apb(1'b0, 12'h388, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        report_and_stop();
    end
endmodule : test_controller_fault_status_reg
